// file: inc/dsc_pkg.sv
// constants for the dual speed clock and power mode controller
// What this block does
// R1: fast rc runs at 4, 8 or 12 MHz by configuration option.
// R2: fast rc selected releases both oscillator pins as general I/O.
// R3: slow crystal is allowed only with the fast rc as high-speed source.
// R4: fast crystal or external rc configuration forbids the slow crystal.
// R5: I/O option lets both oscillator pins act as general I/O.
// R6: low-power bit 0 gives quick-start, 1 gives low-power crystal drive.
// R7: low-power bit clears at power-on.
// R8: software should set low-power bit about 2 s after power-on.
// R9: crystal runs in both drive modes; low-power only slows start-up.
// R10: slow rc keeps running in idle or sleep unless option disables it.
// R11: source select switches system clock between fast rc and crystal.
// R12: source select works only in fast rc plus crystal configuration.
// R13: configured crystal always runs, also in idle or sleep.
// R14: halt enters idle with crystal running, else sleep.
// R15: sleep stops the system oscillator and holds execution at halt.
// R16: sleep keeps memory, registers and port states unchanged.
// R17: halt clears watchdog; it counts on slow clocks, stops on system clock.
// R18: halt sets power-down flag and clears watchdog timeout flag (a timeout command in the same write sets it instead).
// R19: software should keep low-power bit set through idle or sleep.
// R20: source select 0 is fast rc, 1 is crystal; resets to 0.
package dsc_pkg;
  localparam logic [31:0] DSC_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] DSC_STAT_ADDR = 32'h0000_0004;
  localparam logic [31:0] DSC_CMD_ADDR = 32'h0000_0008;
  localparam int CTRL_LOW_POWER_BIT = 0;
  localparam int CTRL_SRC_SEL_BIT = 1;
  localparam int CMD_HALT_BIT = 0;
  localparam int CMD_WAKE_BIT = 1;
  localparam int CMD_CLR_WDT_BIT = 2;
  localparam int CMD_WDT_TIMEOUT_BIT = 3;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // oscillator pin configuration option
  localparam logic [2:0] CFG_FAST_XTAL = 3'h0;
  localparam logic [2:0] CFG_EXT_RC = 3'h1;
  localparam logic [2:0] CFG_FAST_RC = 3'h2;
  localparam logic [2:0] CFG_FAST_RC_SLOW_XTAL = 3'h3;
  localparam logic [2:0] CFG_FAST_RC_IO = 3'h4;
  // fast rc frequency option
  localparam logic [1:0] FRQ_4MHZ = 2'h0;
  localparam logic [1:0] FRQ_8MHZ = 2'h1;
  localparam logic [1:0] FRQ_12MHZ = 2'h2;
  // watchdog clock source option
  localparam logic [1:0] WDT_SRC_SLOW_XTAL = 2'h0;
  localparam logic [1:0] WDT_SRC_SYS_DIV4 = 2'h1;
  localparam logic [1:0] WDT_SRC_SLOW_RC = 2'h2;
  // crystal start-up model: quick start vs low power, in microseconds
  localparam int CLK_MHZ = 250;
  localparam int QUICK_START_US = 4;
  localparam int LOW_POWER_START_US = 16;
  localparam int QUICK_START_CYC = QUICK_START_US * CLK_MHZ;
  localparam int LOW_POWER_START_CYC = LOW_POWER_START_US * CLK_MHZ;
  localparam int START_CNT_W = 13;
  typedef enum logic [2:0] {
    DSC_NORMAL = 3'b001,
    DSC_IDLE = 3'b010,
    DSC_SLEEP = 3'b100
  } dsc_mode_e;
endpackage

// file: tb/dsc_clock_ctrl_test.sv
// self-checking bench for the clock and power mode controller
`timescale 1ns/1ps
module dsc_clock_ctrl_test;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rce = 1, ok, e;
  logic [31:0] pa = 0, pwd = 0, prd, rd;
  logic [2:0] osc = 3, mode;
  logic [1:0] frq = 0, ws = 2, fo;
  logic pr, perr, frce, xen, xlp, rcen, slow, sysen, g1, g2, hold, frz;
  logic wclr, wrun;
  int fails = 0, comparisons = 0;
  logic wclr_seen = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk) if (wclr) wclr_seen <= 1'b1;
  dsc_clock_ctrl uut (.CLK_IN(clk), .RST_IN(rst), .PADDR_IN(pa),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PWDATA_IN(pwd),
    .PRDATA_OUT(prd), .PREADY_OUT(pr), .PSLVERR_OUT(perr), .CFG_OSC_IN(osc),
    .CFG_FREQ_IN(frq), .CFG_SLOW_RC_EN_IN(rce), .CFG_WDT_SRC_IN(ws),
    .SLOW_XTAL_OK_IN(ok), .FAST_RC_EN_OUT(frce), .FAST_RC_FREQ_OUT(fo),
    .SLOW_XTAL_EN_OUT(xen), .SLOW_XTAL_LP_OUT(xlp), .SLOW_RC_EN_OUT(rcen),
    .SYS_SRC_SLOW_OUT(slow), .SYS_CLK_EN_OUT(sysen), .PIN_ONE_GPIO_OUT(g1),
    .PIN_TWO_GPIO_OUT(g2), .CPU_HOLD_OUT(hold), .STATE_FREEZE_OUT(frz),
    .WDT_CLEAR_OUT(wclr), .WDT_RUN_OUT(wrun), .MODE_OUT(mode));
  dsc_xtal_model xtal (.clk_in(clk), .en_in(xen), .lp_in(xlp), .ok_out(ok));
  task stop_test;
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pr !== 1'b1 && n < 16);
    if (pr !== 1'b1) begin
      fails++;
      stop_test;
    end
    rd = prd;
    e = perr;
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task reset(input logic [2:0] o);
    @(posedge clk);
    rst <= 1'b1;
    osc <= o;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  task s_options;
    for (int o = 0; o < 5; o++) begin
      frq <= 2'(o);
      reset(3'(o));
      chk("gpio one", 32'(o == 2 || o == 4), 32'(g1));
      chk("gpio two", 32'(o == 1 || o == 2 || o == 4), 32'(g2));
      chk("crystal", 32'(o == 3), 32'(xen));
      if (o >= 2) chk("freq", (o == 2) ? 32'h2 : 32'h0, 32'(fo));
      bus(1'b0, dsc_pkg::DSC_CTRL_ADDR, 32'h0);
      chk("ctrl reset", 32'h0, rd);
    end
  endtask
  task s_ctrl;
    reset(3'h3);
    bus(1'b1, dsc_pkg::DSC_CTRL_ADDR, 32'h0000_0003);
    settle;
    chk("low power", 32'h1, 32'(xlp));
    chk("slow src", 32'h1, 32'(slow));
    chk("fast rc off", 32'h0, 32'(frce));
    bus(1'b0, dsc_pkg::DSC_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0000_0003, rd);
    reset(3'h2);
    bus(1'b1, dsc_pkg::DSC_CTRL_ADDR, 32'h0000_0002);
    settle;
    chk("no slow mode", 32'h0, 32'(slow));
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
  endtask
  task s_halt;
    reset(3'h3);
    bus(1'b1, dsc_pkg::DSC_CTRL_ADDR, 32'h0000_0001);
    bus(1'b1, dsc_pkg::DSC_CMD_ADDR, 32'h0000_0008);
    chk("no clear yet", 32'h0, 32'(wclr_seen));
    bus(1'b1, dsc_pkg::DSC_CMD_ADDR, 32'h0000_0001);
    settle;
    chk("wdt clear", 32'h1, 32'(wclr_seen));
    chk("idle", 32'(dsc_pkg::DSC_IDLE), 32'(mode));
    chk("hold", 32'h1, 32'(hold && frz && !sysen));
    chk("xtal runs", 32'h1, 32'(xen));
    chk("wdt runs", 32'h1, 32'(wrun && rcen));
    bus(1'b0, dsc_pkg::DSC_STAT_ADDR, 32'h0);
    chk("status", 32'h0000_0009, rd & 32'h0000_001f);
    bus(1'b1, dsc_pkg::DSC_CTRL_ADDR, 32'h0000_0003);
    bus(1'b0, dsc_pkg::DSC_CTRL_ADDR, 32'h0);
    chk("ctrl kept", 32'h1, rd);
    bus(1'b1, dsc_pkg::DSC_CMD_ADDR, 32'h0000_0002);
    settle;
    chk("woken", 32'(dsc_pkg::DSC_NORMAL), 32'(mode));
    ws <= dsc_pkg::WDT_SRC_SYS_DIV4;
    reset(3'h2);
    bus(1'b1, dsc_pkg::DSC_CMD_ADDR, 32'h0000_0001);
    settle;
    chk("sleep", 32'(dsc_pkg::DSC_SLEEP), 32'(mode));
    chk("wdt stop", 32'h0, 32'(wrun));
    ws <= dsc_pkg::WDT_SRC_SLOW_RC;
  endtask
  task s_xtal;
    int n;
    reset(3'h3);
    n = 0;
    do begin
      bus(1'b0, dsc_pkg::DSC_STAT_ADDR, 32'h0);
      n++;
    end while (rd[5] !== 1'b1 && n < 700);
    chk("stable qs", 32'h1, 32'(rd[5]));
    bus(1'b1, dsc_pkg::DSC_CTRL_ADDR, 32'h0000_0001);
    settle;
    bus(1'b0, dsc_pkg::DSC_STAT_ADDR, 32'h0);
    chk("stable lp", 32'h1, 32'(rd[5]));
  endtask
  initial begin
    s_options;
    s_ctrl;
    s_halt;
    s_xtal;
    stop_test;
  end
endmodule

// file: tb/dsc_monitor.sv
// port assertions for the clock and power mode controller
`timescale 1ns/1ps
module dsc_monitor (
  input wire logic CLK_IN, // clock
  input wire logic RST_IN, // reset
  input wire logic [31:0] PADDR_IN, // address
  input wire logic PSEL_IN, // select
  input wire logic PENABLE_IN, // enable
  input wire logic PWRITE_IN, // write
  input wire logic [31:0] PWDATA_IN, // data
  input wire logic PREADY_OUT, // ready
  input wire logic [2:0] CFG_OSC_IN, // pin option
  input wire logic [1:0] CFG_WDT_SRC_IN, // wdt clock
  input wire logic FAST_RC_EN_OUT, // fast rc
  input wire logic SLOW_XTAL_EN_OUT, // crystal
  input wire logic SLOW_XTAL_LP_OUT, // low power
  input wire logic SYS_SRC_SLOW_OUT, // slow mode
  input wire logic SYS_CLK_EN_OUT, // clock gate
  input wire logic PIN_ONE_GPIO_OUT, // pin gpio
  input wire logic CPU_HOLD_OUT, // held
  input wire logic WDT_CLEAR_OUT, // wdt clear
  input wire logic WDT_RUN_OUT, // wdt runs
  input wire logic [2:0] MODE_OUT // mode
);
  wire norm_w = MODE_OUT == dsc_pkg::DSC_NORMAL;
  wire osc3_w = CFG_OSC_IN == dsc_pkg::CFG_FAST_RC_SLOW_XTAL;
  wire halt_w = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && norm_w
    && PADDR_IN == dsc_pkg::DSC_CMD_ADDR
    && PWDATA_IN[dsc_pkg::CMD_HALT_BIT];
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  AST_GPIO: assert property (!$past(RST_IN) |-> PIN_ONE_GPIO_OUT ==
    ($past(CFG_OSC_IN) == 3'h2 || $past(CFG_OSC_IN) == 3'h4))
    else $error("pin one gpio wrong");
  AST_XTAL_EN: assert property (!$past(RST_IN) |-> SLOW_XTAL_EN_OUT ==
    ($past(CFG_OSC_IN) == 3'h3)) else $error("crystal enable wrong");
  AST_LP_RESET: assert property ($fell(RST_IN) |->
    !SLOW_XTAL_LP_OUT ##1 !SLOW_XTAL_LP_OUT) else $error("low power set");
  AST_SLOW_SRC: assert property (SYS_SRC_SLOW_OUT |->
    SLOW_XTAL_EN_OUT && !FAST_RC_EN_OUT) else $error("slow source wrong");
  AST_HALT_MODE: assert property (halt_w |=> MODE_OUT ==
    (osc3_w ? dsc_pkg::DSC_IDLE : dsc_pkg::DSC_SLEEP))
    else $error("halt mode wrong");
  AST_HALT_HOLD: assert property (!norm_w && !$past(norm_w) |->
    CPU_HOLD_OUT && !SYS_CLK_EN_OUT && !FAST_RC_EN_OUT)
    else $error("halt hold wrong");
  AST_WDT_STOP: assert property (!norm_w && !$past(norm_w) &&
    CFG_WDT_SRC_IN == dsc_pkg::WDT_SRC_SYS_DIV4 |-> !WDT_RUN_OUT)
    else $error("watchdog runs in halt");
  AST_WDT_CLEAR: assert property (halt_w |-> ##[1:3] WDT_CLEAR_OUT)
    else $error("no watchdog clear");
endmodule
bind dsc_clock_ctrl dsc_monitor u_mon (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .PADDR_IN(PADDR_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT),
  .CFG_OSC_IN(CFG_OSC_IN), .CFG_WDT_SRC_IN(CFG_WDT_SRC_IN),
  .FAST_RC_EN_OUT(FAST_RC_EN_OUT), .SLOW_XTAL_EN_OUT(SLOW_XTAL_EN_OUT),
  .SLOW_XTAL_LP_OUT(SLOW_XTAL_LP_OUT), .SYS_SRC_SLOW_OUT(SYS_SRC_SLOW_OUT),
  .SYS_CLK_EN_OUT(SYS_CLK_EN_OUT), .PIN_ONE_GPIO_OUT(PIN_ONE_GPIO_OUT),
  .CPU_HOLD_OUT(CPU_HOLD_OUT), .WDT_CLEAR_OUT(WDT_CLEAR_OUT),
  .WDT_RUN_OUT(WDT_RUN_OUT), .MODE_OUT(MODE_OUT));

// file: tb/dsc_xtal_model.sv
// crystal model: reports oscillation after a start-up delay
`timescale 1ns/1ps
module dsc_xtal_model #(parameter int QUICK = 40, parameter int SLOW = 160) (
  input wire logic clk_in, // bench clock
  input wire logic en_in, // crystal powered
  input wire logic lp_in, // low-power drive
  output logic ok_out // oscillating
);
  int cnt = 0;
  initial ok_out = 1'b0;
  always @(posedge clk_in) begin
    if (!en_in) begin
      cnt <= 0;
      ok_out <= 1'b0;
    end else if (cnt >= (lp_in ? SLOW : QUICK)) ok_out <= 1'b1;
    else cnt <= cnt + 1;
  end
endmodule

// file: verilog/dsc_apb.sv
// apb slave decode and register read mux
`timescale 1ns/1ps
module dsc_apb (
  input wire logic [31:0] paddr_in, // address
  input wire logic psel_in, // select
  input wire logic penable_in, // enable
  input wire logic pwrite_in, // direction
  input wire logic [31:0] ctrl_val_in, // control readback
  input wire logic [31:0] stat_val_in, // status readback
  output logic ctrl_wr_out, // write control
  output logic cmd_wr_out, // write command
  output logic rd_out, // read access
  output logic [31:0] rdata_out, // read data
  output logic err_out // unmapped address
);
  wire access = psel_in & penable_in;
  wire hit_ctrl = paddr_in == dsc_pkg::DSC_CTRL_ADDR;
  wire hit_stat = paddr_in == dsc_pkg::DSC_STAT_ADDR;
  wire hit_cmd = paddr_in == dsc_pkg::DSC_CMD_ADDR;
  assign ctrl_wr_out = access & pwrite_in & hit_ctrl;
  assign cmd_wr_out = access & pwrite_in & hit_cmd;
  assign rd_out = access & ~pwrite_in;
  assign err_out = access & ~(hit_ctrl | hit_stat | hit_cmd);
  assign rdata_out = hit_ctrl ? ctrl_val_in :
                     hit_stat ? stat_val_in : 32'h0000_0000;
endmodule

// file: verilog/dsc_clock_ctrl.sv
// clock source selection and halt power mode controller
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module dsc_clock_ctrl (
  input wire logic CLK_IN, // 250 MHz clock
  input wire logic RST_IN, // sync reset, power-on
  input wire logic [31:0] PADDR_IN, // apb address
  input wire logic PSEL_IN, // apb select
  input wire logic PENABLE_IN, // apb enable
  input wire logic PWRITE_IN, // apb direction
  input wire logic [31:0] PWDATA_IN, // apb write data
  output logic [31:0] PRDATA_OUT, // apb read data
  output logic PREADY_OUT, // apb ready
  output logic PSLVERR_OUT, // apb error
  input wire logic [2:0] CFG_OSC_IN, // oscillator pin option
  input wire logic [1:0] CFG_FREQ_IN, // fast rc frequency option
  input wire logic CFG_SLOW_RC_EN_IN, // slow rc enabled option
  input wire logic [1:0] CFG_WDT_SRC_IN, // watchdog clock option
  input wire logic SLOW_XTAL_OK_IN, // crystal oscillating, async
  output logic FAST_RC_EN_OUT, // fast rc oscillator runs
  output logic [1:0] FAST_RC_FREQ_OUT, // fast rc frequency select
  output logic SLOW_XTAL_EN_OUT, // crystal oscillator runs
  output logic SLOW_XTAL_LP_OUT, // crystal low-power drive
  output logic SLOW_RC_EN_OUT, // slow rc oscillator runs
  output logic SYS_SRC_SLOW_OUT, // system clock from crystal
  output logic SYS_CLK_EN_OUT, // system clock gate open
  output logic PIN_ONE_GPIO_OUT, // oscillator pin one is gpio
  output logic PIN_TWO_GPIO_OUT, // oscillator pin two is gpio
  output logic CPU_HOLD_OUT, // execution held at halt
  output logic STATE_FREEZE_OUT, // memory and ports held
  output logic WDT_CLEAR_OUT, // watchdog clear pulse
  output logic WDT_RUN_OUT, // watchdog counts
  output logic [2:0] MODE_OUT // one-hot normal idle sleep
);
  logic [1:0] ctrl_reg;
  logic power_down_flag_reg, timeout_flag_reg, xtal_stable_reg;
  logic [dsc_pkg::START_CNT_W-1:0] start_cnt_reg;
  dsc_pkg::dsc_mode_e mode_reg, mode_next;
  logic xtal_ok_sync;
  logic ctrl_wr, cmd_wr, rd_acc, bus_err;
  logic [31:0] rdata;

  dsc_sync u_sync (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .d_in(SLOW_XTAL_OK_IN),
    .q_out(xtal_ok_sync)
  );

  wire [31:0] ctrl_val = {30'h0000_0000, ctrl_reg};
  wire [31:0] stat_val = {26'h000_0000, xtal_stable_reg,
    mode_reg == dsc_pkg::DSC_SLEEP, mode_reg == dsc_pkg::DSC_IDLE,
    SYS_SRC_SLOW_OUT, timeout_flag_reg, power_down_flag_reg};

  dsc_apb u_apb (
    .paddr_in(PADDR_IN),
    .psel_in(PSEL_IN),
    .penable_in(PENABLE_IN),
    .pwrite_in(PWRITE_IN),
    .ctrl_val_in(ctrl_val),
    .stat_val_in(stat_val),
    .ctrl_wr_out(ctrl_wr),
    .cmd_wr_out(cmd_wr),
    .rd_out(rd_acc),
    .rdata_out(rdata),
    .err_out(bus_err)
  );

  // configuration decode
  wire combo_cfg = CFG_OSC_IN == dsc_pkg::CFG_FAST_RC_SLOW_XTAL; // R3 R4
  wire fast_rc_cfg = combo_cfg | (CFG_OSC_IN == dsc_pkg::CFG_FAST_RC) |
    (CFG_OSC_IN == dsc_pkg::CFG_FAST_RC_IO);
  wire pins_free = (CFG_OSC_IN == dsc_pkg::CFG_FAST_RC) |
    (CFG_OSC_IN == dsc_pkg::CFG_FAST_RC_IO); // R2 R5
  wire pin_two_free = pins_free |
    (CFG_OSC_IN == dsc_pkg::CFG_EXT_RC);
  wire freq_ok = CFG_FREQ_IN != 2'h3;
  wire [1:0] freq_sel = freq_ok ? CFG_FREQ_IN : dsc_pkg::FRQ_4MHZ; // R1

  // commands
  wire cmd_halt = cmd_wr & PWDATA_IN[dsc_pkg::CMD_HALT_BIT];
  wire cmd_wake = cmd_wr & PWDATA_IN[dsc_pkg::CMD_WAKE_BIT];
  wire cmd_clr = cmd_wr & PWDATA_IN[dsc_pkg::CMD_CLR_WDT_BIT];
  wire cmd_to = cmd_wr & PWDATA_IN[dsc_pkg::CMD_WDT_TIMEOUT_BIT];
  wire running = mode_reg == dsc_pkg::DSC_NORMAL;
  wire halt_go = cmd_halt & running;
  wire src_slow = combo_cfg & ctrl_reg[dsc_pkg::CTRL_SRC_SEL_BIT]; // R12 R20
  wire wdt_sys = CFG_WDT_SRC_IN == dsc_pkg::WDT_SRC_SYS_DIV4;
  wire wdt_src_ok = (CFG_WDT_SRC_IN != dsc_pkg::WDT_SRC_SLOW_XTAL) |
    combo_cfg;
  wire xtal_lp = ctrl_reg[dsc_pkg::CTRL_LOW_POWER_BIT]; // R6
  wire [dsc_pkg::START_CNT_W-1:0] start_need = xtal_lp ?
    dsc_pkg::START_CNT_W'(dsc_pkg::LOW_POWER_START_CYC) :
    dsc_pkg::START_CNT_W'(dsc_pkg::QUICK_START_CYC); // R9

  // halt: idle if crystal runs, else sleep
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      dsc_pkg::DSC_NORMAL: begin
        if (halt_go) begin
          mode_next = combo_cfg ? dsc_pkg::DSC_IDLE :
            dsc_pkg::DSC_SLEEP; // R14
        end
      end
      dsc_pkg::DSC_IDLE, dsc_pkg::DSC_SLEEP: begin
        if (cmd_wake | cmd_to) begin
          mode_next = dsc_pkg::DSC_NORMAL;
        end
      end
      default: mode_next = dsc_pkg::DSC_NORMAL;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode_reg <= dsc_pkg::DSC_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // control register, cleared at power-on
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctrl_reg <= dsc_pkg::CTRL_RESET; // R7 R20
    end else if (ctrl_wr & running) begin
      ctrl_reg <= PWDATA_IN[1:0]; // R16
    end
  end

  // power-down and time-out flags
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      power_down_flag_reg <= 1'b0;
      timeout_flag_reg <= 1'b0;
    end else begin
      if (halt_go) begin
        power_down_flag_reg <= 1'b1; // R18
      end else if (cmd_clr & running) begin
        power_down_flag_reg <= 1'b0;
      end
      if (cmd_to) begin
        timeout_flag_reg <= 1'b1;
      end else if (halt_go) begin
        timeout_flag_reg <= 1'b0; // R18
      end
    end
  end

  // crystal start-up tracking, drive mode sets start time
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      start_cnt_reg <= '0;
      xtal_stable_reg <= 1'b0;
    end else if (!combo_cfg || !xtal_ok_sync) begin
      start_cnt_reg <= '0;
      xtal_stable_reg <= 1'b0;
    end else if (start_cnt_reg >= start_need - 1'b1) begin
      xtal_stable_reg <= 1'b1;
    end else begin
      start_cnt_reg <= start_cnt_reg + 1'b1;
    end
  end

  // apb answers in the access cycle; pready is registered
  wire unmapped = (PADDR_IN != dsc_pkg::DSC_CTRL_ADDR) &
    (PADDR_IN != dsc_pkg::DSC_STAT_ADDR) &
    (PADDR_IN != dsc_pkg::DSC_CMD_ADDR);
  wire setup_seen = PSEL_IN & ~PREADY_OUT;
  wire pready_next = setup_seen;
  wire pslverr_next = setup_seen & unmapped;
  wire rdata_load = PSEL_IN & ~PWRITE_IN;

  // next values of the registered outputs
  wire halted_next = mode_next != dsc_pkg::DSC_NORMAL;
  wire fast_rc_en_next = fast_rc_cfg & running & ~src_slow; // R15
  wire slow_xtal_lp_next = combo_cfg & xtal_lp; // R6
  wire wdt_clear_next = halt_go | (cmd_clr & running); // R17
  wire slow_rc_ok = (CFG_WDT_SRC_IN != dsc_pkg::WDT_SRC_SLOW_RC) |
    CFG_SLOW_RC_EN_IN; // R10
  wire wdt_slow_ok = ~wdt_sys & slow_rc_ok;
  wire wdt_run_next = wdt_src_ok & (~halted_next | wdt_slow_ok); // R17

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PREADY_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= pready_next;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PSLVERR_OUT <= 1'b0;
    end else begin
      PSLVERR_OUT <= pslverr_next;
    end
  end

  // read data holds until the next read
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (rdata_load) begin
      PRDATA_OUT <= rdata;
    end
  end

  // oscillator outputs
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      FAST_RC_EN_OUT <= 1'b0;
    end else begin
      FAST_RC_EN_OUT <= fast_rc_en_next; // R15
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      FAST_RC_FREQ_OUT <= dsc_pkg::FRQ_4MHZ;
    end else begin
      FAST_RC_FREQ_OUT <= freq_sel; // R1
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SLOW_XTAL_EN_OUT <= 1'b0;
    end else begin
      SLOW_XTAL_EN_OUT <= combo_cfg; // R3 R4 R13
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SLOW_XTAL_LP_OUT <= 1'b0;
    end else begin
      SLOW_XTAL_LP_OUT <= slow_xtal_lp_next; // R6
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SLOW_RC_EN_OUT <= 1'b0;
    end else begin
      SLOW_RC_EN_OUT <= CFG_SLOW_RC_EN_IN; // R10
    end
  end

  // system clock source and gate
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SYS_SRC_SLOW_OUT <= 1'b0;
    end else begin
      SYS_SRC_SLOW_OUT <= src_slow; // R11
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SYS_CLK_EN_OUT <= 1'b0;
    end else begin
      SYS_CLK_EN_OUT <= ~halted_next; // R15
    end
  end

  // oscillator pins handed back as gpio
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PIN_ONE_GPIO_OUT <= 1'b0;
    end else begin
      PIN_ONE_GPIO_OUT <= pins_free; // R2 R5
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PIN_TWO_GPIO_OUT <= 1'b0;
    end else begin
      PIN_TWO_GPIO_OUT <= pin_two_free; // R2 R5
    end
  end

  // hold outputs
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      CPU_HOLD_OUT <= 1'b0;
    end else begin
      CPU_HOLD_OUT <= halted_next; // R15
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      STATE_FREEZE_OUT <= 1'b0;
    end else begin
      STATE_FREEZE_OUT <= halted_next; // R16
    end
  end

  // watchdog outputs
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      WDT_CLEAR_OUT <= 1'b0;
    end else begin
      WDT_CLEAR_OUT <= wdt_clear_next; // R17
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      WDT_RUN_OUT <= 1'b0;
    end else begin
      WDT_RUN_OUT <= wdt_run_next; // R17 R10
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      MODE_OUT <= dsc_pkg::DSC_NORMAL;
    end else begin
      MODE_OUT <= mode_next; // R14
    end
  end
endmodule

// file: verilog/dsc_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module dsc_sync (
  input wire logic clk_in, // clock
  input wire logic rst_in, // sync reset
  input wire logic d_in, // async level
  output logic q_out // synchronised level
);
  logic meta_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule
